// ===== hdl/mbd_cfg.svh
// address decode, timing and layout constants for the mpu bus glue block
`ifndef MBD_CFG_SVH
`define MBD_CFG_SVH
`define MBD_CLK_MHZ 200
`define MBD_PHI_MHZ_X100 125
// system clocks per half phase period: 200 MHz / 1.25 MHz / 2
`define MBD_PHI_HALF ((`MBD_CLK_MHZ * 100) / (`MBD_PHI_MHZ_X100 * 2))
`define MBD_ROM_TOP_BIT 15
`define MBD_ROM_LOW_BIT 11
`define MBD_ROM_CODES 5'h0C
`define MBD_ROM_HIGH_CODE 5'h0F
`define MBD_ROM_SELECTS 14
`define MBD_RAM_PAIR_BIT 10
// region codes on address bits 15..11 used for ram and i/o
`define MBD_RAM_REGION 5'h0D
`define MBD_IO_REGION 5'h0E
`define MBD_IO_STROBES 12
`define MBD_IO_SERIAL_DATA 4'h0
`define MBD_IO_LATCH_SEL 4'h1
`define MBD_IO_IRQ_STATUS 4'h2
`define MBD_IO_ADAPTER 4'h3
`define MBD_LATCH_CLOCKS 6
`define MBD_SHIFT_DIV 8
`define MBD_BITS 8
`define MBD_IRQ_SOURCES 5
`endif

// ===== hdl/mbd_pkg.sv
// types shared by the mpu bus glue block
package mbd_pkg;
    typedef enum logic [1:0] {MBD_IDLE, MBD_ALIGN, MBD_SHIFT} mbd_ser_state_t;
    typedef logic [7:0] mbd_byte_t;
    typedef logic [15:0] mbd_addr_t;
endpackage : mbd_pkg

// ===== hdl/mbd_phase_gen.sv
// two-phase non-overlapping processor clock generator
`timescale 1ns/1ps
`include "mbd_cfg.svh"
module mbd_phase_gen (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset
    output logic phi1_o, // phase one
    output logic phi2_o, // phase two
    output logic phi2_rise_o // one-cycle pulse at phase two start
);
    logic [7:0] cnt;
    logic half;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            half <= 1'b0;
        end else if (cnt == 8'(`MBD_PHI_HALF - 1)) begin
            cnt <= 8'h00;
            half <= ~half;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // one dead cycle at each edge keeps the phases from overlapping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phi1_o <= 1'b0;
            phi2_o <= 1'b0;
            phi2_rise_o <= 1'b0;
        end else begin
            phi1_o <= ~half && cnt != 8'h00;
            phi2_o <= half && cnt != 8'h00;
            phi2_rise_o <= half && cnt == 8'h01;
        end
    end
endmodule : mbd_phase_gen

// ===== hdl/mbd_glue.sv
// mpu bus qualifier, decoder, interrupt merge and serial port
//
// Overview of operation
// - memory and adapter strobes only during a valid memory cycle
// - device selector enable needs valid cycle and phase one together, but cycles are taken at phase two start, so it never asserts
// - on read the addressed unit drives the bus, buffers in drive mode for i/o region reads only
// - on write the addressed unit captures the bus, adapter receives
// - phase two gives the 1.25 MHz timing reference for sequencing
// - i/o buffer links only while enabled, direction from read/write
// - address bits 15..11 decode to 14 rom selects, codes 0..12 and 15
// - program rom region spans 28K bytes, fetched over the address bus
// - ram pairs of 4-bit parts form bytes, address bit 10 picks pair
// - ram enable lies inside the cycle so writes complete first
// - power fail inhibits all ram addressing
// - address bits 0..3 decode to 12 i/o strobes
// - five request sources merge into one interrupt request
// - merged request line goes low while any source requests
// - interrupt status register shows the requesting sources
// - the interrupt path has no hardware mask
// - control byte written to serial register loads on load enable
// - latch select code stored, decoded to six clocks at phase two/64
// - octal counter makes shift clock every 8 phase two cycles
// - exactly 8 bits shift out during one latch clock period
// - serial data goes out on one of three serial lines
// - two non-overlapping 1.25 MHz phases derived from fast clock
// - 16-bit address bus and 8-bit bidirectional data bus
`timescale 1ns/1ps
`include "mbd_cfg.svh"
module mbd_glue (
    input wire logic clk_i, // 200 MHz system clock
    input wire logic rst_i, // sync reset, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire mbd_pkg::mbd_addr_t wb_adr_i, // processor address
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic power_fail_i, // battery protect active
    input wire logic keypad_request_i, // source level, high = request
    input wire logic integrator_request_i, // source level
    input wire logic conversion_done_request_i, // source level
    input wire logic bus_adapter_request_i, // source level
    input wire logic power_fail_request_i, // source level
    input wire mbd_pkg::mbd_byte_t mem_rdata_i, // rom/ram/adapter data
    output logic phi1_o, // phase one clock
    output logic phi2_o, // phase two clock
    output logic valid_memory_cycle_o, // qualified bus cycle
    output logic read_not_write_o, // bus direction, 1 = read
    output logic [13:0] rom_chip_select_n_o, // rom selects, low active
    output logic [1:0] ram_access_enable_n_o, // ram pair enables
    output logic io_buffer_link_enable_o, // i/o buffer enable
    output logic io_buffer_drive_o, // buffer drives toward processor
    output logic bus_adapter_enable_n_o, // adapter select
    output logic [11:0] io_strobe_o, // i/o strobes
    output mbd_pkg::mbd_byte_t bus_wdata_o, // data toward memory
    output logic irq_n_o, // merged interrupt request, low active
    output logic [5:0] latch_clock_o, // six latch clocks
    output logic [2:0] serial_line_o, // three serial data lines
    output logic serial_busy_o // transfer in progress
);
    import mbd_pkg::*;

    logic phi1, phi2, phi2_rise;
    logic req, take, rd, io_hit, ram_hit, rom_hit;
    logic [4:0] region;
    logic [4:0] irq_src;
    logic serial_load_enable;
    logic [3:0] latch_clock_select;
    logic [2:0] div8;
    logic [3:0] bit_cnt;
    mbd_byte_t shreg;
    mbd_ser_state_t state;
    logic serial_line_a;

    mbd_phase_gen u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phi1_o(phi1),
        .phi2_o(phi2),
        .phi2_rise_o(phi2_rise)
    );

    assign req = wb_cyc_i && wb_stb_i;
    // requests are held until the next phase two start, like a real cycle
    assign take = req && !wb_ack_o && phi2_rise;
    assign rd = !wb_we_i;
    assign region = wb_adr_i[`MBD_ROM_TOP_BIT:`MBD_ROM_LOW_BIT];
    assign rom_hit = rd && (region <= `MBD_ROM_CODES ||
                            region == `MBD_ROM_HIGH_CODE);
    assign ram_hit = region == `MBD_RAM_REGION && !power_fail_i;
    assign io_hit = region == `MBD_IO_REGION;
    assign irq_src = {power_fail_request_i, bus_adapter_request_i,
                      conversion_done_request_i, integrator_request_i,
                      keypad_request_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phi1_o <= 1'b0;
            phi2_o <= 1'b0;
        end else begin
            phi1_o <= phi1;
            phi2_o <= phi2;
        end
    end

    // bus cycle qualifiers and chip selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_memory_cycle_o <= 1'b0;
            read_not_write_o <= 1'b1;
            rom_chip_select_n_o <= '1;
            ram_access_enable_n_o <= 2'b11;
            bus_adapter_enable_n_o <= 1'b1;
            io_buffer_link_enable_o <= 1'b0;
            io_buffer_drive_o <= 1'b0;
            io_strobe_o <= 12'h000;
            bus_wdata_o <= 8'h00;
        end else begin
            valid_memory_cycle_o <= take;
            read_not_write_o <= take ? rd : 1'b1;
            bus_wdata_o <= take ? wb_dat_i[7:0] : bus_wdata_o;
            rom_chip_select_n_o <= '1;
            if (take && rom_hit) begin
                if (region == `MBD_ROM_HIGH_CODE) begin
                    rom_chip_select_n_o[13] <= 1'b0;
                end else begin
                    rom_chip_select_n_o[region[3:0]] <= 1'b0;
                end
            end
            ram_access_enable_n_o <= 2'b11;
            if (take && ram_hit) begin
                // one-cycle enable wholly inside the held request
                ram_access_enable_n_o[wb_adr_i[`MBD_RAM_PAIR_BIT]]
                    <= 1'b0;
            end
            bus_adapter_enable_n_o <= !(take && io_hit &&
                wb_adr_i[3:0] == `MBD_IO_ADAPTER);
            // selector gated by valid cycle and phase one
            io_buffer_link_enable_o <= take && io_hit && phi1;
            io_buffer_drive_o <= take && io_hit && rd;
            io_strobe_o <= 12'h000;
            if (take && io_hit && wb_adr_i[3:0] < 4'(`MBD_IO_STROBES)) begin
                io_strobe_o[wb_adr_i[3:0]] <= 1'b1;
            end
        end
    end

    // wishbone answer: ack one cycle after the cycle is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= take;
            if (take && rd) begin
                if (io_hit && wb_adr_i[3:0] == `MBD_IO_IRQ_STATUS) begin
                    wb_dat_o <= {27'h0, irq_src};
                end else if (io_hit && wb_adr_i[3:0] == `MBD_IO_LATCH_SEL)
                begin
                    wb_dat_o <= {28'h0, latch_clock_select};
                end else if (rom_hit || ram_hit || (io_hit &&
                    wb_adr_i[3:0] < 4'(`MBD_IO_STROBES))) begin
                    wb_dat_o <= {24'h0, mem_rdata_i};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // no mask anywhere on this path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= ~|irq_src;
        end
    end

    // load enable and latch select capture, write side of the port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_load_enable <= 1'b0;
            latch_clock_select <= 4'h0;
        end else begin
            serial_load_enable <= take && io_hit && !rd && wb_sel_i[0] &&
                wb_adr_i[3:0] == `MBD_IO_SERIAL_DATA;
            if (take && io_hit && !rd && wb_sel_i[0] &&
                wb_adr_i[3:0] == `MBD_IO_LATCH_SEL) begin
                latch_clock_select <= wb_dat_i[3:0];
            end
        end
    end

    // octal divider of phase two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div8 <= 3'h0;
        end else if (phi2_rise) begin
            div8 <= div8 + 3'h1;
        end
    end

    // shifter: align to divider, then 8 shifts, msb first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= MBD_IDLE;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            serial_line_a <= 1'b0;
        end else begin
            case (state)
                MBD_IDLE: begin
                    if (serial_load_enable) begin
                        shreg <= bus_wdata_o;
                        state <= MBD_ALIGN;
                    end
                end
                // msb goes out with the latch clock rise, so all 8 bits
                // stand a full shift period inside the latch clock
                MBD_ALIGN: begin
                    if (phi2_rise && div8 == 3'h7) begin
                        state <= MBD_SHIFT;
                        serial_line_a <= shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                        bit_cnt <= 4'h1;
                    end
                end
                MBD_SHIFT: begin
                    if (phi2_rise && div8 == 3'h7) begin
                        if (bit_cnt == 4'(`MBD_BITS)) begin
                            state <= MBD_IDLE;
                        end else begin
                            serial_line_a <= shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                default: state <= MBD_IDLE;
            endcase
        end
    end

    // latch clock high across the whole 8-bit shift; line fans by select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_clock_o <= 6'h00;
            serial_line_o <= 3'h0;
            serial_busy_o <= 1'b0;
        end else begin
            serial_busy_o <= state != MBD_IDLE;
            latch_clock_o <= 6'h00;
            if (state == MBD_SHIFT &&
                latch_clock_select < 4'(`MBD_LATCH_CLOCKS)) begin
                latch_clock_o[latch_clock_select[2:0]] <= 1'b1;
            end
            // line 0 analog latches, 1 bias supply, 2 recorder
            serial_line_o <= {latch_clock_select == 4'h5,
                              latch_clock_select == 4'h4,
                              latch_clock_select < 4'h4}
                             & {3{serial_line_a}};
        end
    end

    // assertions
    strobe_needs_cycle_a: assert property (@(posedge clk_i) disable iff
        (rst_i) (&rom_chip_select_n_o == 1'b0 ||
        ram_access_enable_n_o != 2'b11) |-> valid_memory_cycle_o)
        else $error("strobe outside valid cycle");
    selector_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
        io_buffer_link_enable_o |-> valid_memory_cycle_o &&
        $past(phi1))
        else $error("selector enable without phase one");
    read_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        io_buffer_drive_o |-> read_not_write_o)
        else $error("buffer drives on write");
    rom_one_hot_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot0(~rom_chip_select_n_o))
        else $error("more than one rom selected");
    ram_fail_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(power_fail_i) |-> ram_access_enable_n_o == 2'b11)
        else $error("ram enabled during power fail");
    irq_merge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |irq_src |=> !irq_n_o)
        else $error("request not merged");
    serial_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state == MBD_SHIFT) |-> ##[60:70] state == MBD_SHIFT)
        else $error("shift ended early");
    shift_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == MBD_SHIFT && $changed(bit_cnt) |-> $past(div8) == 3'h7)
        else $error("shift off divider");
    hold_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == MBD_IDLE && $past(state) == MBD_IDLE |->
        $stable(serial_line_a))
        else $error("line moved between transfers");
    cov_rom_c: cover property (@(posedge clk_i) !rom_chip_select_n_o[0]);
    cov_ram_c: cover property (@(posedge clk_i) !ram_access_enable_n_o[1]);
    cov_irq_c: cover property (@(posedge clk_i) $fell(irq_n_o));
    cov_ser_c: cover property (@(posedge clk_i) $fell(serial_busy_o));
endmodule : mbd_glue

// ===== bench/mbd_latch_bank.sv
// remote control latches fed by the serial port
`timescale 1ns/1ps
module mbd_latch_bank #(
    parameter int BIT_CLKS = 1280
) (
    input wire logic clk_i, // system clock
    input wire logic [5:0] latch_clock_i, // six latch clocks
    input wire logic [2:0] serial_line_i, // three serial data lines
    output logic [7:0] last_byte_o, // byte captured by the last latch
    output logic [2:0] last_latch_o, // index of that latch
    output int hold_clks_o // high time of the last latch clock
);
    logic [7:0] shreg = 8'h00;
    logic [5:0] prev = 6'h00;
    logic [7:0] q [6];
    int cnt = 0;
    int sel;
    // latches 0..3 hang on line a, the bias and recorder latches on b and c
    function automatic int line_of(input int k);
        return (k < 4) ? 0 : k - 3;
    endfunction : line_of
    always_comb begin
        sel = 0;
        for (int k = 0; k < 6; k++) if (latch_clock_i[k]) sel = k;
    end
    always @(posedge clk_i) begin
        prev <= latch_clock_i;
        if (|latch_clock_i) begin
            cnt <= cnt + 1;
            // sample mid-bit, so edge placement inside a bit does not matter
            if (cnt % BIT_CLKS == BIT_CLKS / 2)
                shreg <= {shreg[6:0], serial_line_i[line_of(sel)]};
        end else begin
            cnt <= 0;
        end
        for (int k = 0; k < 6; k++) begin
            if (prev[k] && !latch_clock_i[k]) begin
                q[k] <= shreg;
                last_byte_o <= shreg;
                last_latch_o <= 3'(k);
                hold_clks_o <= cnt;
            end
        end
    end
endmodule : mbd_latch_bank

// ===== bench/tb_mbd_glue.sv
// self-checking bench for the mpu bus glue block
`timescale 1ns/1ps
`include "mbd_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_mbd_glue;
    import mbd_pkg::*;
    localparam int BIT_CLKS = `MBD_SHIFT_DIV * 2 * `MBD_PHI_HALF;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_sel_i = 0;
    mbd_addr_t wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic wb_ack_o, power_fail_i = 0, phi1_o, phi2_o, vmc, rnw, adp_n, link;
    logic drv, irq_n_o, serial_busy_o;
    logic [4:0] src = 0;
    mbd_byte_t mem_rdata_i = 0, bus_wdata_o, last_byte;
    logic [13:0] rom_n, s_rom;
    logic [1:0] ram_n, s_ram;
    logic [11:0] io_stb, s_io;
    logic [5:0] latch_clock_o;
    logic [2:0] serial_line_o, last_latch;
    mbd_byte_t s_wd;
    logic s_vmc, s_rnw, s_adp, s_drv;
    int errors = 0, n_tests = 0, hold_clks, overlap = 0;

    mbd_glue i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .power_fail_i(power_fail_i),
        .keypad_request_i(src[0]), .integrator_request_i(src[1]),
        .conversion_done_request_i(src[2]), .bus_adapter_request_i(src[3]),
        .power_fail_request_i(src[4]), .mem_rdata_i(mem_rdata_i),
        .phi1_o(phi1_o), .phi2_o(phi2_o), .valid_memory_cycle_o(vmc),
        .read_not_write_o(rnw), .rom_chip_select_n_o(rom_n),
        .ram_access_enable_n_o(ram_n), .io_buffer_link_enable_o(link),
        .io_buffer_drive_o(drv), .bus_adapter_enable_n_o(adp_n),
        .io_strobe_o(io_stb), .bus_wdata_o(bus_wdata_o), .irq_n_o(irq_n_o),
        .latch_clock_o(latch_clock_o), .serial_line_o(serial_line_o),
        .serial_busy_o(serial_busy_o));
    mbd_latch_bank #(.BIT_CLKS(BIT_CLKS)) i_latch (.clk_i(clk_i),
        .latch_clock_i(latch_clock_o), .serial_line_i(serial_line_o),
        .last_byte_o(last_byte), .last_latch_o(last_latch),
        .hold_clks_o(hold_clks));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (phi1_o === 1'b1 && phi2_o === 1'b1) overlap++;

    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // one classic cycle; strobes are snapshot in the acknowledge cycle
    task automatic bus(input logic we, input mbd_addr_t a,
                       input mbd_byte_t wd, output mbd_byte_t rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, wd};
        do begin @(posedge clk_i); n++; end
        while (wb_ack_o !== 1'b1 && n < 300);
        `CHK(wb_ack_o, 1'b1)
        rd = wb_dat_o[7:0];
        {s_rom, s_ram, s_io, s_wd} = {rom_n, ram_n, io_stb, bus_wdata_o};
        {s_vmc, s_rnw, s_adp, s_drv} = {vmc, rnw, adp_n, drv};
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    initial begin
        repeat (100000) @(posedge clk_i);
        errors++;
        results();
    end

    initial begin
        mbd_byte_t d, r;
        logic [4:0] c, v;
        realtime t0;
        int p;
        void'($urandom(85129));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK({rom_n, ram_n, adp_n, irq_n_o, rnw}, 19'h7FFFF)
        `CHK({io_stb, latch_clock_o, vmc, serial_busy_o}, 20'h0)
        @(posedge phi2_o) t0 = $realtime;
        @(posedge phi2_o);
        `CHK(int'(($realtime - t0) / 5.0), 2 * `MBD_PHI_HALF)
        for (int k = 0; k < 14; k++) begin
            c = (k == 13) ? 5'h0F : 5'(k);
            d = 8'($urandom);
            mem_rdata_i <= d;
            bus(1'b0, {c, 11'($urandom)}, 8'h00, r);
            `CHK(s_rom, ~(14'h1 << k))
            `CHK(r, d)
            `CHK({s_vmc, s_rnw, s_ram, s_adp, s_drv}, 6'b111110)
        end
        for (int k = 0; k < 4; k++) begin
            power_fail_i <= k[1];
            d = 8'($urandom);
            bus(1'b1, {5'h0D, k[0], 10'($urandom)}, d, r);
            `CHK(s_ram, k[1] ? 2'h3 : ~(2'h1 << k[0]))
            `CHK({s_rnw, s_wd}, {1'b0, d})
            mem_rdata_i <= d;
            bus(1'b0, {5'h0D, k[0], 10'($urandom)}, 8'h00, r);
            `CHK(s_ram, k[1] ? 2'h3 : ~(2'h1 << k[0]))
            if (!k[1]) `CHK(r, d)
        end
        power_fail_i <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            bus(1'b0, {5'h0E, 7'h0, 4'(k)}, 8'h00, r);
            `CHK(s_io, (k < 12) ? 12'h1 << k : 12'h0)
            `CHK({s_adp, s_vmc, s_drv | (k > 11)}, {k != 3, 2'b11})
            if (k > 11) `CHK(r, 8'h00)
        end
        for (int k = 0; k < 12; k++) begin
            v = (k < 5) ? 5'h1 << k : (k == 5) ? 5'h0 : 5'($urandom);
            src <= v;
            repeat (3) @(posedge clk_i);
            `CHK(irq_n_o, ~|v)
            bus(1'b0, 16'h7002, 8'h00, r);
            `CHK(r[4:0], v)
        end
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 5'h02 : 5'(k + 3);
            d = 8'($urandom);
            bus(1'b1, 16'h7000, d, r);
            bus(1'b1, 16'h7001, {4'h0, c[3:0]}, r);
            bus(1'b0, 16'h7001, 8'h00, r);
            `CHK(r[3:0], c[3:0])
            src <= 5'h02;
            p = 0;
            do begin @(negedge clk_i); p++; end
            while (serial_busy_o !== 1'b1 && p < 12000);
            repeat (2) @(negedge clk_i);
            `CHK(irq_n_o, 1'b0)
            src <= 5'h00;
            p = 0;
            do begin @(negedge clk_i); p++; end
            while (serial_busy_o !== 1'b0 && p < 12000);
            repeat (2) @(negedge clk_i);
            `CHK({last_latch, last_byte}, {c[2:0], d})
            `CHK(hold_clks / BIT_CLKS, 8)
            `CHK(serial_line_o[(c < 4) ? 0 : c - 3], d[0])
        end
        `CHK(overlap, 0)
        results();
    end
endmodule : tb_mbd_glue
